// file: vrc_pkg.sv
// package of constants and types for the value restore command block
package vrc_pkg;
  // command codes
  localparam logic [7:0] VRC_CMD_RESTORE  = 8'h0e;
  localparam logic [7:0] VRC_CMD_TRANSFER = 8'h0f;
  // parameter buffer byte offsets
  localparam int VRC_PAR_BLOCK  = 'h00;
  localparam int VRC_PAR_SEL    = 'h01;
  localparam int VRC_PAR_KEY    = 'h02;
  localparam int VRC_PAR_BYTES  = 8;
  // key selector fields
  localparam int VRC_SEL_KEYB_BIT   = 7;
  localparam int VRC_SEL_INLINE_BIT = 6;
  localparam int VRC_SLOT_W         = 6;
  localparam logic [5:0] VRC_SLOT_MAX = 6'h27;
  // register byte addresses
  localparam logic [7:0] VRC_ADDR_RESULT = 8'h00;
  localparam logic [7:0] VRC_ADDR_CMD    = 8'h04;
  localparam logic [7:0] VRC_ADDR_PAR0   = 8'h08;
  localparam logic [7:0] VRC_ADDR_PAR1   = 8'h0c;
  localparam logic [7:0] VRC_ADDR_KIDX   = 8'h10;
  localparam logic [7:0] VRC_ADDR_KLO    = 8'h14;
  localparam logic [7:0] VRC_ADDR_KHI    = 8'h18;
  localparam int VRC_BUSY_BIT = 8;
  // result codes and reset values
  localparam logic [7:0] VRC_RES_OK       = 8'h00;
  localparam logic [7:0] VRC_RES_BAD_CMD  = 8'h01;
  localparam logic [7:0] VRC_RES_BAD_SLOT = 8'h02;
  localparam logic [7:0] VRC_RES_AUTH     = 8'h03;
  localparam logic [7:0] VRC_RES_READ     = 8'h04;
  localparam logic [7:0] VRC_RES_NOT_VAL  = 8'h05;
  localparam logic [7:0] VRC_RES_TAG      = 8'h06;
  localparam logic [7:0] VRC_RESULT_RST   = 8'h00;
  localparam logic [7:0] VRC_CMD_RST      = 8'h00;
  // operations asked of the tag transceiver
  typedef enum logic [1:0] {VRC_OP_AUTH, VRC_OP_READ, VRC_OP_RESTORE, VRC_OP_TRANSFER} vrc_op_e;
endpackage

// file: vrc_fmt_check.sv
// value-block format checker for one 16-byte tag block
`timescale 1ns/1ps
`default_nettype none
module vrc_fmt_check (
  input  wire logic [127:0] blk_in,
  output logic              ok_out
);
  logic [31:0] val;
  logic [7:0]  adr;
  // value, inverted value, value copy, then address byte four times with inversions
  assign val    = blk_in[31:0];
  assign adr    = blk_in[103:96];
  assign ok_out = (blk_in[63:32] == ~val) && (blk_in[95:64] == val) &&
                  (blk_in[111:104] == ~adr) && (blk_in[119:112] == adr) &&
                  (blk_in[127:120] == ~adr);
endmodule
`default_nettype wire

// file: vrc_key_store.sv
// stored authentication key slots, written by software, read by slot number
`timescale 1ns/1ps
`default_nettype none
module vrc_key_store #(
  parameter int SLOTS = 40
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wr_in,
  input  wire logic [5:0]  wr_slot_in,
  input  wire logic [47:0] wr_key_in,
  input  wire logic [5:0]  rd_slot_in,
  output logic      [47:0] rd_key_out
);
  logic [47:0] keys [SLOTS];

  if (SLOTS < 1 || SLOTS > 64) begin : g_chk
    $error("key store slot count out of range");
  end

  // combinational read, out-of-range slots read zero
  assign rd_key_out = (int'(rd_slot_in) < SLOTS) ? keys[rd_slot_in] : 48'h0;

  // slot write port
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < SLOTS; i++) keys[i] <= 48'h0;
    end else if (wr_in && int'(wr_slot_in) < SLOTS) begin
      keys[wr_slot_in] <= wr_key_in;
    end
  end
endmodule
`default_nettype wire

// file: vrc_value_restore.sv
// value restore / transfer command engine with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module vrc_value_restore
  import vrc_pkg::*;
#(
  parameter int SLOTS = 40
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 hsel_in,
  input  wire logic [7:0]           haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  output logic                      tag_req_out,
  output vrc_pkg::vrc_op_e          tag_op_out,
  output logic      [7:0]           tag_block_out,
  output logic      [47:0]          tag_key_out,
  output logic                      tag_key_b_out,
  input  wire logic                 tag_ack_in,
  input  wire logic                 tag_err_in,
  input  wire logic [127:0]         tag_rdata_in
);
  import vrc_pkg::*;

  if (SLOTS != int'(VRC_SLOT_MAX) + 1) begin : g_chk
    $error("slot count must match the selector's valid slot range");
  end

  typedef enum logic [2:0] {S_IDLE, S_AUTH, S_READ, S_VALUE, S_DONE} vrc_state_e;

  // bus-side state
  logic [7:0]  par [VRC_PAR_BYTES];
  logic [7:0]  next_par [VRC_PAR_BYTES];
  logic        dph_wr, next_dph_wr;
  logic [7:0]  dph_addr, next_dph_addr;
  logic [31:0] hrdata, next_hrdata;
  logic [5:0]  kidx, next_kidx;
  logic [31:0] klo, next_klo;
  logic [15:0] khi, next_khi;
  logic        key_wr;
  logic        start, cmd_ok, slot_bad;

  // engine state
  vrc_state_e  state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic [7:0]  result, next_result;
  logic [47:0] key, next_key;
  logic        key_b, next_key_b;
  logic        fmt_ok, next_fmt_ok;
  logic [47:0] slot_key;
  logic        blk_ok;
  logic        busy;

  assign busy          = (state != S_IDLE);
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata;

  // a command write in the data phase starts the engine when idle
  assign start    = dph_wr && dph_addr == VRC_ADDR_CMD && !busy;
  assign cmd_ok   = hwdata_in[7:0] == VRC_CMD_RESTORE || hwdata_in[7:0] == VRC_CMD_TRANSFER;
  assign slot_bad = !par[VRC_PAR_SEL][VRC_SEL_INLINE_BIT] &&
                    par[VRC_PAR_SEL][VRC_SLOT_W-1:0] > VRC_SLOT_MAX;
  assign key_wr   = dph_wr && dph_addr == VRC_ADDR_KHI && !busy;

  vrc_key_store #(.SLOTS(SLOTS)) u_keys (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .wr_in      (key_wr),
    .wr_slot_in (kidx),
    .wr_key_in  ({hwdata_in[15:0], klo}),
    .rd_slot_in (par[VRC_PAR_SEL][VRC_SLOT_W-1:0]),
    .rd_key_out (slot_key)
  );

  vrc_fmt_check u_fmt (
    .blk_in (tag_rdata_in),
    .ok_out (blk_ok)
  );

  // ahb-lite slave: capture address phase, apply writes in data phase
  always_comb begin
    next_dph_wr   = 1'b0;
    next_dph_addr = dph_addr;
    next_hrdata   = hrdata;
    next_kidx     = kidx;
    next_klo      = klo;
    next_khi      = khi;
    for (int i = 0; i < VRC_PAR_BYTES; i++) next_par[i] = par[i];
    if (hsel_in && hready_in && htrans_in[1]) begin
      next_dph_wr   = hwrite_in;
      next_dph_addr = haddr_in;
      if (!hwrite_in) begin
        case ({haddr_in[7:2], 2'h0})
          VRC_ADDR_RESULT: next_hrdata = {23'h0, busy, result};
          VRC_ADDR_CMD:    next_hrdata = {24'h0, cmd};
          VRC_ADDR_PAR0:   next_hrdata = {par[3], par[2], par[1], par[0]};
          VRC_ADDR_PAR1:   next_hrdata = {par[7], par[6], par[5], par[4]};
          VRC_ADDR_KIDX:   next_hrdata = {26'h0, kidx};
          VRC_ADDR_KLO:    next_hrdata = klo;
          VRC_ADDR_KHI:    next_hrdata = {16'h0, khi};
          default:         next_hrdata = 32'h0;
        endcase
      end
    end
    // parameters are frozen while a command runs
    if (dph_wr && !busy) begin
      case (dph_addr)
        VRC_ADDR_PAR0: for (int i = 0; i < 4; i++) next_par[i] = hwdata_in[8*i +: 8];
        VRC_ADDR_PAR1: for (int i = 0; i < 4; i++) next_par[i+4] = hwdata_in[8*i +: 8];
        VRC_ADDR_KIDX: next_kidx = hwdata_in[5:0];
        VRC_ADDR_KLO:  next_klo = hwdata_in;
        VRC_ADDR_KHI:  next_khi = hwdata_in[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dph_wr   <= 1'b0;
      dph_addr <= 8'h00;
      hrdata   <= 32'h0;
      kidx     <= 6'h00;
      klo      <= 32'h0;
      khi      <= 16'h0;
      for (int i = 0; i < VRC_PAR_BYTES; i++) par[i] <= 8'h00;
    end else begin
      dph_wr   <= next_dph_wr;
      dph_addr <= next_dph_addr;
      hrdata   <= next_hrdata;
      kidx     <= next_kidx;
      klo      <= next_klo;
      khi      <= next_khi;
      for (int i = 0; i < VRC_PAR_BYTES; i++) par[i] <= next_par[i];
    end
  end

  // command sequencer: authenticate, read and check (restore only), then restore or transfer
  always_comb begin
    next_state  = state;
    next_cmd    = cmd;
    next_result = result;
    next_key    = key;
    next_key_b  = key_b;
    next_fmt_ok = fmt_ok;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_cmd    = hwdata_in[7:0];
          next_fmt_ok = 1'b0;
          next_key_b  = par[VRC_PAR_SEL][VRC_SEL_KEYB_BIT];
          if (par[VRC_PAR_SEL][VRC_SEL_INLINE_BIT]) begin
            next_key = {par[VRC_PAR_KEY+5], par[VRC_PAR_KEY+4], par[VRC_PAR_KEY+3],
                        par[VRC_PAR_KEY+2], par[VRC_PAR_KEY+1], par[VRC_PAR_KEY]};
          end else begin
            next_key = slot_key;
          end
          if (!cmd_ok) begin
            next_result = VRC_RES_BAD_CMD;
            next_state  = S_DONE;
          end else if (slot_bad) begin
            next_result = VRC_RES_BAD_SLOT;
            next_state  = S_DONE;
          end else begin
            next_state = S_AUTH;
          end
        end
      end
      S_AUTH: begin
        if (tag_ack_in) begin
          if (tag_err_in) begin
            next_result = VRC_RES_AUTH;
            next_state  = S_DONE;
          end else if (cmd == VRC_CMD_TRANSFER) begin
            next_state = S_VALUE;
          end else begin
            next_state = S_READ;
          end
        end
      end
      S_READ: begin
        if (tag_ack_in) begin
          if (tag_err_in) begin
            next_result = VRC_RES_READ;
            next_state  = S_DONE;
          end else if (!blk_ok) begin
            next_result = VRC_RES_NOT_VAL;
            next_state  = S_DONE;
          end else begin
            next_fmt_ok = 1'b1;
            next_state  = S_VALUE;
          end
        end
      end
      S_VALUE: begin
        if (tag_ack_in) begin
          next_result = tag_err_in ? VRC_RES_TAG : VRC_RES_OK;
          next_state  = S_DONE;
        end
      end
      S_DONE:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state  <= S_IDLE;
      cmd    <= VRC_CMD_RST;
      result <= VRC_RESULT_RST;
      key    <= 48'h0;
      key_b  <= 1'b0;
      fmt_ok <= 1'b0;
    end else begin
      state  <= next_state;
      cmd    <= next_cmd;
      result <= next_result;
      key    <= next_key;
      key_b  <= next_key_b;
      fmt_ok <= next_fmt_ok;
    end
  end

  // tag request outputs, block index passed as an ordinal unchanged
  assign tag_req_out   = (state == S_AUTH) || (state == S_READ) || (state == S_VALUE);
  assign tag_block_out = par[VRC_PAR_BLOCK];
  assign tag_key_out   = key;
  assign tag_key_b_out = key_b;
  always_comb begin
    case (state)
      S_READ:  tag_op_out = VRC_OP_READ;
      S_VALUE: tag_op_out = (cmd == VRC_CMD_TRANSFER) ? VRC_OP_TRANSFER : VRC_OP_RESTORE;
      default: tag_op_out = VRC_OP_AUTH;
    endcase
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_start_restore: assert property (
    start && hwdata_in[7:0] == VRC_CMD_RESTORE && !slot_bad |=> tag_req_out && tag_op_out == VRC_OP_AUTH)
    else $error("restore code did not start authentication");
  a_bad_slot_err: assert property (
    start && cmd_ok && slot_bad |=> !tag_req_out ##1 (result == VRC_RES_BAD_SLOT && !busy))
    else $error("bad key slot not reported");
  a_key_kind: assert property (
    start && cmd_ok && !slot_bad |=> tag_key_b_out == $past(par[VRC_PAR_SEL][VRC_SEL_KEYB_BIT]))
    else $error("key a/b choice wrong");
  a_inline_key: assert property (
    start && cmd_ok && par[VRC_PAR_SEL][VRC_SEL_INLINE_BIT]
      |=> tag_key_out[7:0] == par[VRC_PAR_KEY] && tag_key_out[47:40] == par[VRC_PAR_KEY+5])
    else $error("inline key not assembled lsb first");
  a_slot_key: assert property (
    start && cmd_ok && !slot_bad && !par[VRC_PAR_SEL][VRC_SEL_INLINE_BIT]
      |=> tag_key_out == $past(slot_key))
    else $error("stored slot key not used");
  a_block_ord: assert property (
    tag_req_out && !tag_ack_in |=> tag_req_out && $stable(tag_block_out) && $stable(tag_key_out))
    else $error("block ordinal or key changed while a request stood");
  a_restore_fmt: assert property (
    tag_req_out && tag_op_out == VRC_OP_RESTORE |-> fmt_ok && cmd == VRC_CMD_RESTORE)
    else $error("restore issued without a value-formatted block");
  a_restore_end: assert property (
    state == S_VALUE && tag_ack_in && cmd == VRC_CMD_RESTORE |=> !tag_req_out ##1 state == S_IDLE)
    else $error("restore did not finish after loading the register");
  a_transfer_op: assert property (
    state == S_AUTH && tag_ack_in && !tag_err_in && cmd == VRC_CMD_TRANSFER
      |=> tag_req_out && tag_op_out == VRC_OP_TRANSFER)
    else $error("transfer did not follow authentication");
  a_not_value: assert property (
    state == S_READ && tag_ack_in && !tag_err_in && !blk_ok
      |=> !tag_req_out && result == VRC_RES_NOT_VAL)
    else $error("badly formatted block was not refused");
  a_read_first: assert property (
    state == S_AUTH && tag_ack_in && !tag_err_in && cmd == VRC_CMD_RESTORE
      |=> tag_req_out && tag_op_out == VRC_OP_READ)
    else $error("restore did not read the block first");
  a_bad_cmd: assert property (
    start && !cmd_ok |=> !tag_req_out ##1 (result == VRC_RES_BAD_CMD && !busy))
    else $error("unknown command code not reported");

  c_restore_ok: cover property (state == S_VALUE && tag_ack_in && !tag_err_in && cmd == VRC_CMD_RESTORE);
  c_not_value: cover property (state == S_READ && tag_ack_in && !tag_err_in && !blk_ok);
  c_transfer: cover property (state == S_VALUE && tag_ack_in && cmd == VRC_CMD_TRANSFER);
  c_bad_slot: cover property (start && cmd_ok && slot_bad);
endmodule
`default_nettype wire

// file: vrc_tag_model.sv
// behavioural tag transceiver that answers the engine's tag link
`timescale 1ns/1ps
`default_nettype none
module vrc_tag_model
  import vrc_pkg::*;
(
  input  wire logic           mclk_in,
  input  wire logic           rst_n_in,
  input  wire logic           req_in,
  input  wire vrc_pkg::vrc_op_e op_in,
  input  wire logic [7:0]     block_in,
  input  wire logic [47:0]    key_in,
  input  wire logic           key_b_in,
  input  wire logic [3:0]     delay_in,
  input  wire logic           err_en_in,
  input  wire vrc_pkg::vrc_op_e err_op_in,
  input  wire logic [127:0]   blk_in,
  input  wire logic           clr_in,
  output logic                ack_out,
  output logic                err_out,
  output logic      [127:0]   rdata_out,
  output logic      [7:0]     hist_out,
  output logic      [3:0]     n_ops_out,
  output logic      [47:0]    key_out,
  output logic                key_b_out,
  output logic      [7:0]     block_out
);
  logic [3:0] wait_cnt;

  // block data only meaningful with ack; otherwise an inverted pattern
  assign rdata_out = ack_out ? blk_in : ~blk_in;

  // answer each request delay_in+1 cycles after it is raised and log what was asked
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_cnt  <= 4'h0;
      ack_out   <= 1'h0;
      err_out   <= 1'h0;
      hist_out  <= 8'h00;
      n_ops_out <= 4'h0;
      key_out   <= 48'h0;
      key_b_out <= 1'h0;
      block_out <= 8'h00;
    end else begin
      ack_out <= 1'h0;
      err_out <= 1'h0;
      if (req_in && !ack_out) begin
        if (wait_cnt == delay_in) begin
          ack_out  <= 1'h1;
          err_out  <= err_en_in && (op_in == err_op_in);
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
      if (clr_in) begin
        hist_out  <= 8'h00;
        n_ops_out <= 4'h0;
      end else if (req_in && ack_out) begin
        hist_out  <= {hist_out[5:0], op_in};
        n_ops_out <= n_ops_out + 4'h1;
        key_out   <= key_in;
        key_b_out <= key_b_in;
        block_out <= block_in;
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the value restore command engine
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vrc_pkg::*;
  logic         mclk;
  logic         rst_n = 1'h0;
  logic [7:0]   haddr = 8'h00;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'h0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hready, hresp, req, key_b, ack, err, m_key_b;
  logic         clr = 1'h0;
  logic         err_en = 1'h0;
  vrc_op_e      op, err_op = VRC_OP_AUTH;
  logic [7:0]   blk_no, hist, m_blk;
  logic [47:0]  key, m_key;
  logic [3:0]   dly = 4'h0;
  logic [3:0]   n_ops;
  logic [127:0] rdata;
  logic [127:0] blk = 128'h0;
  int           fails = 0;
  int           n_compared = 0;

  vrc_value_restore vrc_value_restore_inst (.mclk_in(mclk), .rst_n_in(rst_n), .hsel_in(1'h1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .tag_req_out(req), .tag_op_out(op), .tag_block_out(blk_no),
    .tag_key_out(key), .tag_key_b_out(key_b), .tag_ack_in(ack), .tag_err_in(err),
    .tag_rdata_in(rdata));
  vrc_tag_model vrc_tag_model_inst (.mclk_in(mclk), .rst_n_in(rst_n), .req_in(req),
    .op_in(op), .block_in(blk_no), .key_in(key), .key_b_in(key_b), .delay_in(dly),
    .err_en_in(err_en), .err_op_in(err_op), .blk_in(blk), .clr_in(clr), .ack_out(ack),
    .err_out(err), .rdata_out(rdata), .hist_out(hist), .n_ops_out(n_ops), .key_out(m_key),
    .key_b_out(m_key_b), .block_out(m_blk));

  // free-running 125 MHz clock
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  task automatic results();
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // wait for hready high at a rising edge, bounded
  task automatic wait_rdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (hready === 1'h1) return;
    end
    fails++;
    results();
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask

  // well-formed value block: value, inverse, value, address bytes
  function automatic logic [127:0] fmt(input logic [31:0] v, input logic [7:0] a);
    return {~a, a, ~a, a, v, ~v, v};
  endfunction

  // load parameters, issue a command and poll until busy drops
  task automatic run(input logic [31:0] p0, input logic [31:0] p1, input logic [7:0] cmd,
                     output logic [31:0] r);
    clr <= 1'h1;
    wr(VRC_ADDR_PAR0, p0);
    clr <= 1'h0;
    wr(VRC_ADDR_PAR1, p1);
    wr(VRC_ADDR_CMD, {24'h0, cmd});
    for (int i = 0; i < 60; i++) begin
      bus(1'h0, VRC_ADDR_RESULT, 32'h0, r);
      if (r[VRC_BUSY_BIT] === 1'h0) return;
    end
    fails++;
    results();
  endtask

  task automatic sc_reset();
    logic [31:0] r;
    bus(1'h0, VRC_ADDR_RESULT, 32'h0, r);
    check("result after reset", r, {24'h0, VRC_RESULT_RST});
    check("idle request", req, 1'h0);
    check("bus response", hresp, 1'h0);
    check("bus ready", hready, 1'h1);
  endtask

  // stored slot 39, key b, slow tag
  task automatic sc_slot_keyb();
    logic [31:0] r;
    dly <= 4'h3;
    blk <= fmt(32'h1234_5678, 8'h24);
    wr(VRC_ADDR_KIDX, 32'h27);
    wr(VRC_ADDR_KLO, 32'h1234_5678);
    wr(VRC_ADDR_KHI, 32'h0000_9abc);
    run(32'h0000_a724, 32'h0, VRC_CMD_RESTORE, r);
    check("restore result", r[7:0], VRC_RES_OK);
    check("op order", hist[5:0], 6'h06);
    check("block ordinal", m_blk, 8'h24);
    check("slot key", m_key, 48'h9abc_1234_5678);
    check("key b", m_key_b, 1'h1);
    repeat (4) @(posedge mclk);
    check("no further op", n_ops, 4'h3);
    check("request idle", req, 1'h0);
    bus(1'h0, VRC_ADDR_KHI, 32'h0, r);
    check("key high readback", r, 32'h0000_9abc);
  endtask

  // inline key overrides slot 63, key a, immediate tag
  task automatic sc_inline();
    logic [31:0] r;
    dly <= 4'h0;
    blk <= fmt(32'h0000_0001, 8'h05);
    run(32'h2211_7f05, 32'h6655_4433, VRC_CMD_RESTORE, r);
    check("inline result", r[7:0], VRC_RES_OK);
    check("inline key", m_key, 48'h6655_4433_2211);
    check("key a", m_key_b, 1'h0);
  endtask

  task automatic sc_bad_format();
    logic [31:0] r;
    blk <= fmt(32'h0000_0010, 8'h08) ^ {16'h0100, 112'h0};
    run(32'h0000_0008, 32'h0, VRC_CMD_RESTORE, r);
    check("format result", r[7:0], VRC_RES_NOT_VAL);
    check("no restore", n_ops, 4'h2);
  endtask

  task automatic sc_bad_slot();
    logic [31:0] r;
    run(32'h0000_2801, 32'h0, VRC_CMD_RESTORE, r);
    check("slot result", r[7:0], VRC_RES_BAD_SLOT);
    check("no auth", n_ops, 4'h0);
  endtask

  // persist the restored value
  task automatic sc_transfer();
    logic [31:0] r;
    dly <= 4'h2;
    run(32'h0000_0106, 32'h0, VRC_CMD_TRANSFER, r);
    check("transfer result", r[7:0], VRC_RES_OK);
    check("transfer order", hist[3:0], 4'h3);
    check("transfer block", m_blk, 8'h06);
    bus(1'h0, VRC_ADDR_CMD, 32'h0, r);
    check("command readback", r, {24'h0, VRC_CMD_TRANSFER});
    bus(1'h0, VRC_ADDR_PAR0, 32'h0, r);
    check("parameter readback", r, 32'h0000_0106);
  endtask

  task automatic sc_faults();
    logic [31:0] r;
    run(32'h0000_0102, 32'h0, 8'h0d, r);
    check("bad command", r[7:0], VRC_RES_BAD_CMD);
    err_en <= 1'h1;
    run(32'h0000_0102, 32'h0, VRC_CMD_RESTORE, r);
    check("auth fail", r[7:0], VRC_RES_AUTH);
    check("stop after fail", n_ops, 4'h1);
    err_op <= VRC_OP_READ;
    run(32'h0000_0102, 32'h0, VRC_CMD_RESTORE, r);
    check("read fail", r[7:0], VRC_RES_READ);
    check("no restore after read fail", n_ops, 4'h2);
    err_op <= VRC_OP_RESTORE;
    blk <= fmt(32'h0000_0020, 8'h02);
    run(32'h0000_0102, 32'h0, VRC_CMD_RESTORE, r);
    check("load fail", r[7:0], VRC_RES_TAG);
    check("ops before load fail", n_ops, 4'h3);
    err_en <= 1'h0;
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    sc_reset();
    sc_slot_keyb();
    sc_inline();
    sc_bad_format();
    sc_bad_slot();
    sc_transfer();
    sc_faults();
    results();
  end
endmodule
`default_nettype wire
